//--- serial_host_defs.svh
// Register offsets, field positions, reset values and codes of the host serial register file
// Summary of operation
// - Offset 0: receive/transmit, divisor low when latched
// - Offset 1: interrupt enable, divisor high when latched
// - Divisor bytes stored only, never steer hardware
// - Non-FIFO receive read returns firmware's byte
// - FIFO receive read fetches next engine-memory byte
// - FIFO transmit write stores byte into engine memory
// - Enable bit 0 passes receive ready/timeout
// - Enable bit 1 interrupts on transmit empty
// - Enable bit 2 passes line status interrupts
// - Enable bit 3 passes modem status interrupts
// - Five priority levels, top source coded
// - Identification frozen during read, updated after
// - Identification bits 7,6 mirror FIFO enable
// - Bit 0 low when pending, resets high
// - Priority code reset only by engine reset
// - Other registers reset by host or D3-D0
// - Line control 03h, identification 01h, others 00h
// - Line and modem status read-only, clear-on-read
// - Offset 2: writes FIFO control, reads identification
// - FIFO enable change clears both FIFOs
`ifndef SERIAL_HOST_DEFS_SVH
`define SERIAL_HOST_DEFS_SVH

// Register offsets
`define OFS_DATA        3'h0
`define OFS_IER         3'h1
`define OFS_IDENT       3'h2
`define OFS_LINE_CTRL   3'h3
`define OFS_MODEM_CTRL  3'h4
`define OFS_LINE_STAT   3'h5
`define OFS_MODEM_STAT  3'h6
`define OFS_SCRATCH     3'h7

// Reset values
`define RST_BYTE        8'h00
`define RST_LINE_CTRL   8'h03
`define RST_CODE        3'h0

// Field positions
`define LCR_LATCH_BIT   7
`define FCR_FIFO_ON     0
`define FCR_RX_CLEAR    1
`define FCR_TX_CLEAR    2
`define IER_RX_READY    0
`define IER_TX_EMPTY    1
`define IER_LINE_STAT   2
`define IER_MODEM_STAT  3
`define IER_USED_MASK   8'h0F
`define MCR_USED_MASK   8'h1F

// Priority codes reported in identification bits 3:1
`define CODE_LINE_STAT  3'h3
`define CODE_RX_READY   3'h2
`define CODE_RX_TIMEOUT 3'h6
`define CODE_TX_EMPTY   3'h1
`define CODE_MODEM_STAT 3'h0
`define CODE_NONE       3'h0

`endif

//--- serial_host_pkg.sv
// Types shared by the host serial register file
package serial_host_pkg;

  // One host access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Interrupt sources raised by firmware, levels
  typedef struct packed {
    logic line_status;
    logic rx_ready;
    logic rx_timeout;
    logic tx_empty;
    logic modem_status;
  } irq_src_t;

  // Configuration shown to firmware
  typedef struct packed {
    logic [7:0] line_ctrl;
    logic [7:0] modem_ctrl;
    logic [7:0] irq_enable;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic       fifo_on;
  } fw_cfg_t;

  // Access state machine, Gray coded along idle -> mem_wait -> answer
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_MEM_WAIT = 2'b01,
    ST_ANSWER   = 2'b11
  } acc_state_t;

endpackage : serial_host_pkg

//--- serial_host_regs.sv
// Host-facing register file of a firmware-emulated serial port
`include "serial_host_defs.svh"

module serial_host_regs (
  // Clock and resets
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic                       d3_to_d0,
  input  wire logic                       engine_rst,
  // Host access port
  input  wire serial_host_pkg::host_req_t host_req,
  output logic                            host_ack,
  output logic [7:0]                      host_rdata,
  output logic                            host_irq,
  // Firmware side, non-FIFO data and status
  input  wire logic                       fw_rx_load,
  input  wire logic [7:0]                 fw_rx_data,
  input  wire serial_host_pkg::irq_src_t  irq_src,
  input  wire logic [7:0]                 line_status_in,
  input  wire logic [7:0]                 modem_status_in,
  output logic                            rx_byte_taken,
  output logic                            tx_byte_valid,
  output logic [7:0]                      tx_byte,
  output logic                            line_status_read,
  output logic                            modem_status_read,
  output serial_host_pkg::fw_cfg_t        fw_cfg,
  // Engine memory FIFO side
  output logic                            mem_rx_rd_req,
  input  wire logic                       mem_rx_rd_valid,
  input  wire logic [7:0]                 mem_rx_rd_data,
  output logic                            mem_tx_wr,
  output logic [7:0]                      mem_tx_data,
  output logic                            fifo_rx_clear,
  output logic                            fifo_tx_clear
);
  import serial_host_pkg::*;

  // How the register file behaves
  // Host accesses are one-cycle strobes, taken only while idle.
  // A request made while an access is outstanding is dropped silently,
  // so the host must wait for the acknowledge before the next one.
  // Every access is acknowledged one cycle after it is taken, except a
  // FIFO-mode receive read, which waits for engine memory to answer.
  // The latch bit of line control steers offsets 0 and 1: divisor
  // bytes when set; receive, transmit and interrupt enable when clear.
  // Divisor bytes are storage only; no timing in here depends on them.
  // Non-FIFO transmit hands the byte to firmware as a one-cycle pulse;
  // FIFO transmit writes it to engine memory; nothing else is buffered.
  // Non-FIFO receive returns the byte that firmware loaded last.
  // Identification read data is captured at the taking edge, and the
  // stored code and pending flag hold still until the acknowledge.
  // The interrupt request is not frozen: a source that appears during
  // an identification read still raises it at once.
  // Offsets 5 and 6 return firmware's status bytes unchanged; firmware
  // clears their clear-on-read bits on the read pulses.
  // Host system reset and the D3-to-D0 transition reset everything
  // except the stored priority code, which only engine reset clears.
  // Trade-off: a single outstanding access keeps the decode simple at
  // the cost of throughput, which a byte-wide legacy port does not need.

  acc_state_t state;
  logic       host_reset;
  logic       take;
  logic       latch_on;
  logic [7:0] receive_byte;
  logic [7:0] scratch_byte;
  logic [2:0] interrupt_priority_code;
  logic [2:0] next_code;
  logic       no_interrupt_pending;
  logic       next_pending;
  logic       ident_frozen;
  logic       rx_ready_irq_on;
  logic       line_or_tx_empty_irq_on;
  logic       line_irq_on;
  logic       modem_status_irq_on;
  logic [7:0] read_mux;
  logic       rx_fifo_read;
  logic       fcr_write;
  logic       mode_change;
  logic       tx_write;

  // Host system reset and the D3-to-D0 transition reset the same state
  assign host_reset = srst | d3_to_d0;
  assign take       = (state == ST_IDLE) & (host_req.rd | host_req.wr);
  assign latch_on   = fw_cfg.line_ctrl[`LCR_LATCH_BIT];

  assign rx_ready_irq_on         = fw_cfg.irq_enable[`IER_RX_READY];
  assign line_or_tx_empty_irq_on = fw_cfg.irq_enable[`IER_TX_EMPTY];
  assign line_irq_on             = fw_cfg.irq_enable[`IER_LINE_STAT];
  assign modem_status_irq_on     = fw_cfg.irq_enable[`IER_MODEM_STAT];

  // A receive read in FIFO mode must wait for engine memory
  assign rx_fifo_read = take & host_req.rd & ~latch_on
                      & (host_req.addr == `OFS_DATA) & fw_cfg.fifo_on;

  // Access sequencing: requests are taken only in idle, one at a time
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rx_fifo_read) begin
            state <= ST_MEM_WAIT;
          end else if (take) begin
            state <= ST_ANSWER;
          end
        end
        ST_MEM_WAIT: begin
          if (mem_rx_rd_valid) begin
            state <= ST_ANSWER;
          end
        end
        ST_ANSWER: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Host-written configuration registers
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      fw_cfg.line_ctrl    <= `RST_LINE_CTRL;
      fw_cfg.modem_ctrl   <= `RST_BYTE;
      fw_cfg.irq_enable   <= `RST_BYTE;
      fw_cfg.divisor_low  <= `RST_BYTE;
      fw_cfg.divisor_high <= `RST_BYTE;
      fw_cfg.fifo_on      <= 1'b0;
      scratch_byte        <= `RST_BYTE;
    end else if (take & host_req.wr) begin
      if (host_req.addr == `OFS_DATA) begin
        if (latch_on) begin
          fw_cfg.divisor_low <= host_req.wdata;
        end
      end else if (host_req.addr == `OFS_IER) begin
        if (latch_on) begin
          fw_cfg.divisor_high <= host_req.wdata;
        end else begin
          fw_cfg.irq_enable <= host_req.wdata & `IER_USED_MASK;
        end
      end else if (host_req.addr == `OFS_IDENT) begin
        fw_cfg.fifo_on <= host_req.wdata[`FCR_FIFO_ON];
      end else if (host_req.addr == `OFS_LINE_CTRL) begin
        fw_cfg.line_ctrl <= host_req.wdata;
      end else if (host_req.addr == `OFS_MODEM_CTRL) begin
        fw_cfg.modem_ctrl <= host_req.wdata & `MCR_USED_MASK;
      end else if (host_req.addr == `OFS_SCRATCH) begin
        scratch_byte <= host_req.wdata;
      end
    end
  end

  // FIFO control write, and a change of the enable bit that it carries
  assign fcr_write   = take & host_req.wr & (host_req.addr == `OFS_IDENT);
  assign mode_change = fcr_write & (host_req.wdata[`FCR_FIFO_ON] != fw_cfg.fifo_on);

  // Receive FIFO clear: self-clearing pulse on request or on a mode change
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      fifo_rx_clear <= 1'b0;
    end else begin
      fifo_rx_clear <= mode_change | (fcr_write & host_req.wdata[`FCR_RX_CLEAR]);
    end
  end

  // Transmit FIFO clear: same rule as the receive side
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      fifo_tx_clear <= 1'b0;
    end else begin
      fifo_tx_clear <= mode_change | (fcr_write & host_req.wdata[`FCR_TX_CLEAR]);
    end
  end

  // Receive byte placed by firmware for non-FIFO reads
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      receive_byte <= `RST_BYTE;
    end else if (fw_rx_load) begin
      receive_byte <= fw_rx_data;
    end
  end

  // Host transmit write: offset 0 with the latch bit clear
  assign tx_write = take & host_req.wr & ~latch_on & (host_req.addr == `OFS_DATA);

  // Non-FIFO transmit: byte handed to firmware with a one-cycle valid
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      tx_byte_valid <= 1'b0;
      tx_byte       <= `RST_BYTE;
    end else begin
      tx_byte_valid <= tx_write & ~fw_cfg.fifo_on;
      if (tx_write & ~fw_cfg.fifo_on) begin
        tx_byte <= host_req.wdata;
      end
    end
  end

  // FIFO transmit: hardware writes the byte into engine memory
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      mem_tx_wr   <= 1'b0;
      mem_tx_data <= `RST_BYTE;
    end else begin
      mem_tx_wr <= tx_write & fw_cfg.fifo_on;
      if (tx_write & fw_cfg.fifo_on) begin
        mem_tx_data <= host_req.wdata;
      end
    end
  end

  // Engine memory read request, one pulse per FIFO receive read
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      mem_rx_rd_req <= 1'b0;
    end else begin
      mem_rx_rd_req <= rx_fifo_read;
    end
  end

  // Priority encoder over enabled sources, line status highest
  always_comb begin
    next_pending = 1'b1;
    if (irq_src.line_status & line_irq_on) begin
      next_code = `CODE_LINE_STAT;
    end else if (irq_src.rx_ready & rx_ready_irq_on) begin
      next_code = `CODE_RX_READY;
    end else if (irq_src.rx_timeout & rx_ready_irq_on) begin
      next_code = `CODE_RX_TIMEOUT;
    end else if (irq_src.tx_empty & line_or_tx_empty_irq_on) begin
      next_code = `CODE_TX_EMPTY;
    end else if (irq_src.modem_status & modem_status_irq_on) begin
      next_code = `CODE_MODEM_STAT;
    end else begin
      next_code    = `CODE_NONE;
      next_pending = 1'b0;
    end
  end

  // Freeze window: from a taken identification read until its answer
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      ident_frozen <= 1'b0;
    end else if (take & host_req.rd & (host_req.addr == `OFS_IDENT)) begin
      ident_frozen <= 1'b1;
    end else if (state == ST_ANSWER) begin
      ident_frozen <= 1'b0;
    end
  end

  // Priority code survives host reset; only engine reset clears it
  always_ff @(posedge mclk) begin
    if (engine_rst) begin
      interrupt_priority_code <= `RST_CODE;
    end else if (~ident_frozen) begin
      interrupt_priority_code <= next_code;
    end
  end

  // Pending flag follows the frozen indication; the interrupt request stays live
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      no_interrupt_pending <= 1'b1;
    end else if (~ident_frozen) begin
      no_interrupt_pending <= ~next_pending;
    end
  end

  // Request is live, not frozen, so a new source is never hidden
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= next_pending;
    end
  end

  // Read data selection
  always_comb begin
    read_mux = `RST_BYTE;
    if (host_req.addr == `OFS_DATA) begin
      if (latch_on) begin
        read_mux = fw_cfg.divisor_low;
      end else begin
        read_mux = receive_byte;
      end
    end else if (host_req.addr == `OFS_IER) begin
      if (latch_on) begin
        read_mux = fw_cfg.divisor_high;
      end else begin
        read_mux = fw_cfg.irq_enable;
      end
    end else if (host_req.addr == `OFS_IDENT) begin
      read_mux = {fw_cfg.fifo_on, fw_cfg.fifo_on, 2'b00,
                  next_code, ~next_pending};
      if (ident_frozen) begin
        read_mux = {fw_cfg.fifo_on, fw_cfg.fifo_on, 2'b00,
                    interrupt_priority_code, no_interrupt_pending};
      end
    end else if (host_req.addr == `OFS_LINE_CTRL) begin
      read_mux = fw_cfg.line_ctrl;
    end else if (host_req.addr == `OFS_MODEM_CTRL) begin
      read_mux = fw_cfg.modem_ctrl;
    end else if (host_req.addr == `OFS_LINE_STAT) begin
      read_mux = line_status_in;
    end else if (host_req.addr == `OFS_MODEM_STAT) begin
      read_mux = modem_status_in;
    end else if (host_req.addr == `OFS_SCRATCH) begin
      read_mux = scratch_byte;
    end
  end

  // Read data capture; identification is captured at the taking edge
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      host_rdata <= `RST_BYTE;
    end else if ((state == ST_MEM_WAIT) & mem_rx_rd_valid) begin
      host_rdata <= mem_rx_rd_data;
    end else if (take & host_req.rd & ~rx_fifo_read) begin
      host_rdata <= read_mux;
    end else if (take & host_req.wr) begin
      host_rdata <= `RST_BYTE;
    end
  end

  // Acknowledge: the cycle after a take, or after engine memory answers
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      host_ack <= 1'b0;
    end else if (state == ST_IDLE) begin
      host_ack <= take & ~rx_fifo_read;
    end else begin
      host_ack <= (state == ST_MEM_WAIT) & mem_rx_rd_valid;
    end
  end

  // Receive byte taken by the host in non-FIFO mode, for firmware
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      rx_byte_taken <= 1'b0;
    end else begin
      rx_byte_taken <= take & host_req.rd & ~latch_on & ~fw_cfg.fifo_on
                     & (host_req.addr == `OFS_DATA);
    end
  end

  // Line status read pulse; firmware clears its clear-on-read bits on it
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      line_status_read <= 1'b0;
    end else begin
      line_status_read <= take & host_req.rd & (host_req.addr == `OFS_LINE_STAT);
    end
  end

  // Modem status read pulse, same use as the line status one
  always_ff @(posedge mclk) begin
    if (host_reset) begin
      modem_status_read <= 1'b0;
    end else begin
      modem_status_read <= take & host_req.rd & (host_req.addr == `OFS_MODEM_STAT);
    end
  end

endmodule : serial_host_regs

//--- host_regs_monitor.sv
// Port-level checker for the host serial register file
`include "serial_host_defs.svh"

module host_regs_monitor (
  // Clock and resets
  input wire logic                       mclk,
  input wire logic                       srst,
  input wire logic                       d3_to_d0,
  // Host side
  input wire serial_host_pkg::host_req_t host_req,
  input wire logic                       host_ack,
  input wire logic [7:0]                 host_rdata,
  input wire logic                       host_irq,
  // Firmware and engine side
  input wire serial_host_pkg::irq_src_t  irq_src,
  input wire logic [7:0]                 line_status_in,
  input wire logic                       tx_byte_valid,
  input wire logic [7:0]                 tx_byte,
  input wire logic                       line_status_read,
  input wire serial_host_pkg::fw_cfg_t   fw_cfg,
  input wire logic                       mem_rx_rd_req,
  input wire logic                       mem_rx_rd_valid,
  input wire logic [7:0]                 mem_rx_rd_data,
  input wire logic                       mem_tx_wr,
  input wire logic [7:0]                 mem_tx_data,
  input wire logic                       fifo_rx_clear,
  input wire logic                       fifo_tx_clear
);
  import serial_host_pkg::*;

  // Request classes; the bench never issues a request while one is outstanding
  wire       latch = fw_cfg.line_ctrl[`LCR_LATCH_BIT];
  wire       wr0   = host_req.wr && host_req.addr == `OFS_DATA && !latch;
  wire       rd0   = host_req.rd && host_req.addr == `OFS_DATA && !latch;
  wire [7:0] ie    = fw_cfg.irq_enable;
  wire       pend  = ie[0] & (irq_src.rx_ready | irq_src.rx_timeout) | ie[1] & irq_src.tx_empty
                   | ie[2] & irq_src.line_status | ie[3] & irq_src.modem_status;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || d3_to_d0);

  property p_tx; wr0 && !fw_cfg.fifo_on |=> tx_byte_valid && tx_byte == $past(host_req.wdata); endproperty
  a_tx: assert property (p_tx) else $error("transmit byte not passed on");
  property p_mtx; wr0 && fw_cfg.fifo_on
    |=> mem_tx_wr && mem_tx_data == $past(host_req.wdata) && !tx_byte_valid; endproperty
  a_mtx: assert property (p_mtx) else $error("fifo transmit write missing");
  property p_mrx; rd0 && fw_cfg.fifo_on |=> mem_rx_rd_req ##1 !host_ack; endproperty
  a_mrx: assert property (p_mrx) else $error("fifo receive fetch missing");
  property p_rxack; mem_rx_rd_valid |=> host_ack && host_rdata == $past(mem_rx_rd_data); endproperty
  a_rxack: assert property (p_rxack) else $error("fifo receive byte not returned");
  property p_irq; 1'b1 |=> host_irq == $past(pend); endproperty
  a_irq: assert property (p_irq) else $error("host interrupt wrong");
  property p_ier; fw_cfg.irq_enable[7:4] == 4'h0; endproperty
  a_ier: assert property (p_ier) else $error("reserved enable bits set");
  property p_lcr; $fell(srst) |-> fw_cfg.line_ctrl == 8'h03 && fw_cfg.irq_enable == 8'h00; endproperty
  a_lcr: assert property (p_lcr) else $error("reset values wrong");
  property p_clr; host_req.wr && host_req.addr == `OFS_IDENT && host_req.wdata[0] != fw_cfg.fifo_on
    |=> fifo_rx_clear && fifo_tx_clear; endproperty
  a_clr: assert property (p_clr) else $error("fifo clear missing");
  property p_id; host_req.rd && host_req.addr == `OFS_IDENT
    |=> host_ack && host_rdata[7:4] == {{2{$past(fw_cfg.fifo_on)}}, 2'b00}; endproperty
  a_id: assert property (p_id) else $error("identification upper bits wrong");
  property p_div; host_req.wr && host_req.addr == `OFS_IER && latch
    |=> fw_cfg.divisor_high == $past(host_req.wdata) && $stable(fw_cfg.irq_enable); endproperty
  a_div: assert property (p_div) else $error("divisor high write wrong");
  property p_lsr; host_req.rd && host_req.addr == `OFS_LINE_STAT
    |=> line_status_read && host_rdata == $past(line_status_in); endproperty
  a_lsr: assert property (p_lsr) else $error("line status read wrong");

  // Main scenarios
  c_fifo: cover property (mem_rx_rd_valid);
  c_irq:  cover property ($rose(host_irq));
  c_clr:  cover property (fifo_rx_clear);
  c_div:  cover property (host_req.wr && latch);
endmodule : host_regs_monitor

bind serial_host_regs host_regs_monitor mon_u (.*);

//--- mem_fifo_model.sv
// Engine memory model answering receive fetches, alternately fast and slow
module mem_fifo_model (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  srst,
  // Fetch handshake
  input  wire logic  mem_rx_rd_req,
  output logic       mem_rx_rd_valid,
  output logic [7:0] mem_rx_rd_data
);
  logic [7:0] next_byte;
  logic [2:0] wait_n;
  logic       slow;

  // Data toggles while not valid, so a late sample never matches a stale byte
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_rx_rd_valid <= 1'b0;
      mem_rx_rd_data  <= 8'h00;
      next_byte       <= 8'hB0;
      wait_n          <= 3'h0;
      slow            <= 1'b0;
    end else begin
      mem_rx_rd_valid <= (wait_n == 3'h1);
      mem_rx_rd_data  <= (wait_n == 3'h1) ? next_byte : ~mem_rx_rd_data;
      if (wait_n == 3'h1) next_byte <= next_byte + 8'h01;
      if (mem_rx_rd_req) begin
        wait_n <= slow ? 3'h4 : 3'h1;
        slow   <= ~slow;
      end else if (wait_n != 3'h0) wait_n <= wait_n - 3'h1;
    end
  end
endmodule : mem_fifo_model

//--- tb_top.sv
// Self-checking bench for the host serial register file
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_host_pkg::*;

  logic       mclk = 0, srst = 1, d3_to_d0 = 0, engine_rst = 1, fw_rx_load = 0;
  host_req_t  host_req = '0;
  irq_src_t   irq_src = '0;
  logic [7:0] fw_rx_data = 0, line_status_in = 0, modem_status_in = 0;
  logic       host_ack, host_irq, rx_byte_taken, tx_byte_valid, line_status_read, modem_status_read;
  logic       mem_rx_rd_req, mem_rx_rd_valid, mem_tx_wr, fifo_rx_clear, fifo_tx_clear;
  logic [7:0] host_rdata, tx_byte, mem_rx_rd_data, mem_tx_data, q;
  logic [6:0] sd;
  fw_cfg_t    fw_cfg;
  int         error_cnt = 0, n_compared = 0;
  logic [4:0] srcs [6] = '{5'h1F, 5'h0F, 5'h07, 5'h03, 5'h01, 5'h00};
  logic [7:0] ids  [6] = '{8'h06, 8'h04, 8'h0C, 8'h02, 8'h00, 8'h01};
  logic [4:0] one  [5] = '{5'h08, 5'h04, 5'h02, 5'h10, 5'h01};
  logic [7:0] ies  [5] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08};
  logic [7:0] oid  [5] = '{8'h04, 8'h0C, 8'h02, 8'h06, 8'h00};

  always #5 mclk = ~mclk;

  serial_host_regs dut_u (.*);
  mem_fifo_model mdl_u (.*);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // One strobe cycle, then wait for the acknowledge; side pulses captured with it
  task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    host_req <= '{r, !r, a, d};
    @(posedge mclk);
    host_req <= '0;
    #1;
    n = 0;
    while (host_ack !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    q  = host_rdata;
    sd = {tx_byte_valid, mem_tx_wr, fifo_rx_clear, fifo_tx_clear, rx_byte_taken, line_status_read, modem_status_read};
    if (host_ack !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t no acknowledge", $time);
      end_of_test();
    end
  endtask : acc

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    acc(1'b1, a, 8'h00);
    chk(q, e, "read");
  endtask : rd

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b0, a, d);
  endtask : wr

  initial begin
    repeat (10) @(posedge mclk);
    srst       <= 1'b0;
    engine_rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), a == 2 ? 8'h01 : a == 3 ? 8'h03 : 8'h00);
    wr(3'h3, 8'h80);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    $display("defaults done");
    // Latched offsets reach the divisor bytes only
    wr(3'h0, 8'h5A);
    chk({1'b0, sd}, 8'h00, "no transmit");
    wr(3'h1, 8'hA5);
    rd(3'h0, 8'h5A);
    rd(3'h1, 8'hA5);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F);
    wr(3'h7, 8'h96);
    rd(3'h7, 8'h96);
    wr(3'h3, 8'h80);
    rd(3'h1, 8'hA5);
    wr(3'h3, 8'h00);
    $display("latch done");
    // Non-FIFO data path
    @(posedge mclk);
    fw_rx_load <= 1'b1;
    fw_rx_data <= 8'h3C;
    @(posedge mclk);
    fw_rx_load <= 1'b0;
    rd(3'h0, 8'h3C);
    chk({1'b0, sd}, 8'h04, "taken pulse");
    wr(3'h0, 8'hC3);
    chk({1'b0, sd}, 8'h40, "tx pulse");
    chk(tx_byte, 8'hC3, "tx byte");
    $display("data done");
    // Priority ladder, then each enable bit alone and masked
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      irq_src <= srcs[i];
      rd(3'h2, ids[i]);
      chk({7'h0, host_irq}, {7'h0, i < 5}, "irq");
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      irq_src <= one[i];
      wr(3'h1, ies[i]);
      rd(3'h2, oid[i]);
      chk({7'h0, host_irq}, 8'h01, "irq on");
      wr(3'h1, ~ies[i] & 8'h0F);
      rd(3'h2, 8'h01);
      chk({7'h0, host_irq}, 8'h00, "irq off");
    end
    $display("interrupts done");
    // FIFO mode
    @(posedge mclk);
    irq_src <= '0;
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h01);
    chk({1'b0, sd}, 8'h18, "clears");
    rd(3'h2, 8'hC1);
    wr(3'h0, 8'h77);
    chk({1'b0, sd}, 8'h20, "mem write");
    chk(mem_tx_data, 8'h77, "mem data");
    rd(3'h0, 8'hB0);
    rd(3'h0, 8'hB1);
    wr(3'h2, 8'h01);
    chk({1'b0, sd}, 8'h00, "no clears");
    wr(3'h2, 8'h00);
    chk({1'b0, sd}, 8'h18, "clears off");
    rd(3'h2, 8'h01);
    $display("fifo done");
    // Status reads, then power-state reset
    @(posedge mclk);
    line_status_in  <= 8'hA1;
    modem_status_in <= 8'h5E;
    irq_src         <= 5'h10;
    wr(3'h1, 8'h04);
    wr(3'h3, 8'h1B);
    wr(3'h4, 8'hFF);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'hA1);
    chk({1'b0, sd}, 8'h02, "lsr pulse");
    rd(3'h6, 8'h5E);
    chk({1'b0, sd}, 8'h01, "msr pulse");
    rd(3'h2, 8'h06);
    @(posedge mclk);
    d3_to_d0 <= 1'b1;
    @(posedge mclk);
    d3_to_d0 <= 1'b0;
    rd(3'h3, 8'h03);
    rd(3'h7, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h4, 8'h00);
    acc(1'b1, 3'h2, 8'h00);
    chk(q & 8'hF1, 8'h01, "ident bit0");
    $display("reset done");
    end_of_test();
  end
endmodule : tb_top
